// >>> hw/sector_protect_pkg.sv
// Constants, register map and types for the sector protection status block
package sector_protect_pkg;

   // ----------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int STRB_W = DATA_W / 8;

   // ----------------------------------------------------------------
   // Sector array
   // ----------------------------------------------------------------
   localparam int SECTOR_W = 8;
   localparam int NUM_SECTORS = 256;
   localparam logic LOCK_BIT_DEFAULT = 1'b1;
   localparam logic [SECTOR_W-1:0] SECTOR_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_SECTOR_SEL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_COMMAND = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_PERSIST_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_VOLATILE_STATUS = 8'h0c;

   // ----------------------------------------------------------------
   // Fields and values
   // ----------------------------------------------------------------
   localparam int CMD_RD_PERSIST_BIT = 0;
   localparam int CMD_RD_VOLATILE_BIT = 1;
   localparam int STATUS_W = 8;
   localparam int STATUS_LSB = 0;
   localparam logic [STATUS_W-1:0] STATUS_ALL_ONES = 8'hff;
   localparam logic [STATUS_W-1:0] STATUS_ALL_ZEROS = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int KIND_PERSIST = 0;
   localparam int KIND_VOLATILE = 1;
   localparam int NUM_KINDS = 2;

   // ----------------------------------------------------------------
   // Register select, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      SEL_NONE     = 5'h01,
      SEL_SECTOR   = 5'h02,
      SEL_COMMAND  = 5'h04,
      SEL_PERSIST  = 5'h08,
      SEL_VOLATILE = 5'h10
   } reg_sel_t;

endpackage

// >>> hw/lock_bit_store.sv
// One bit per sector of lock state, with a write port and an immediate read port
`timescale 1ns/100ps
`default_nettype none
module lock_bit_store (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   // Write port
   input wire logic wr_en,
   input wire logic [sector_protect_pkg::SECTOR_W-1:0] wr_sector,
   input wire logic wr_bit,
   // Read port
   input wire logic [sector_protect_pkg::SECTOR_W-1:0] rd_sector,
   output logic rd_bit
);

   logic [sector_protect_pkg::NUM_SECTORS-1:0] bits_q;

   // Every sector starts unprotected
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bits_q <= {sector_protect_pkg::NUM_SECTORS{sector_protect_pkg::LOCK_BIT_DEFAULT}};
      end else if (ce && wr_en) begin
         bits_q[wr_sector] <= wr_bit;
      end
   end

   // Read is combinational so a command latches the bit in one cycle
   assign rd_bit = bits_q[rd_sector];

endmodule
`default_nettype wire

// >>> hw/sector_protect_status_read.sv
// Per-sector protection status readback behind an AXI4-Lite slave
//
// Overview of operation
// - Persistent status byte follows lock bit of sector named by last persistent read.
// - Persistent status reads ff when that bit is one, 00 when zero.
// - Persistent status is eight bits, read/write, nonvolatile, defaults to all ones; here rst also sets every persistent lock bit back to one.
// - Volatile status byte follows lock bit of sector named by last volatile read.
// - Volatile status reads ff when that bit is one, 00 when zero.
// - Volatile status is eight bits, read/write, volatile, comes up all ones.
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module sector_protect_status_read (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   // AXI4-Lite write address
   input wire logic [sector_protect_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [sector_protect_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [sector_protect_pkg::STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [sector_protect_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [sector_protect_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic sector_protect_pkg::reg_sel_t decode_addr(
      input logic [sector_protect_pkg::ADDR_W-1:0] a
   );
      case (a)
         sector_protect_pkg::OFF_SECTOR_SEL: decode_addr = sector_protect_pkg::SEL_SECTOR;
         sector_protect_pkg::OFF_COMMAND: decode_addr = sector_protect_pkg::SEL_COMMAND;
         sector_protect_pkg::OFF_PERSIST_STATUS: decode_addr = sector_protect_pkg::SEL_PERSIST;
         sector_protect_pkg::OFF_VOLATILE_STATUS: decode_addr = sector_protect_pkg::SEL_VOLATILE;
         default: decode_addr = sector_protect_pkg::SEL_NONE;
      endcase
   endfunction

   // A single lock bit spreads over the whole byte
   function automatic logic [sector_protect_pkg::STATUS_W-1:0] fill_byte(input logic b);
      fill_byte = b ? sector_protect_pkg::STATUS_ALL_ONES : sector_protect_pkg::STATUS_ALL_ZEROS;
   endfunction

   // ----------------------------------------------------------------
   // Write channels
   // ----------------------------------------------------------------
   logic aw_full_q;
   logic w_full_q;
   logic [sector_protect_pkg::ADDR_W-1:0] aw_addr_q;
   logic [sector_protect_pkg::DATA_W-1:0] w_data_q;
   logic [sector_protect_pkg::STRB_W-1:0] w_strb_q;
   logic do_write;
   logic lane0;
   sector_protect_pkg::reg_sel_t wr_sel;

   assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;
   assign wr_sel = decode_addr(aw_addr_q);
   assign lane0 = w_strb_q[0];

   // Address and data are taken in either order and held until the write is done
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= '0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= sector_protect_pkg::RESP_OKAY;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_sel == sector_protect_pkg::SEL_NONE) ?
                           sector_protect_pkg::RESP_SLVERR : sector_protect_pkg::RESP_OKAY;
         end
         // Channels reopen only after the response, so one write at a time
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Sector select
   // ----------------------------------------------------------------
   logic [sector_protect_pkg::SECTOR_W-1:0] sector_sel_q;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sector_sel_q <= sector_protect_pkg::SECTOR_RESET;
      end else if (ce && do_write && lane0 && wr_sel == sector_protect_pkg::SEL_SECTOR) begin
         sector_sel_q <= w_data_q[sector_protect_pkg::SECTOR_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Lock bit stores and status bytes, one per kind
   // ----------------------------------------------------------------
   logic [sector_protect_pkg::NUM_KINDS-1:0] rd_cmd;
   logic [sector_protect_pkg::NUM_KINDS-1:0] wr_status;
   logic [sector_protect_pkg::NUM_KINDS-1:0] rd_bit;
   logic [sector_protect_pkg::STATUS_W-1:0] status_q [sector_protect_pkg::NUM_KINDS];

   genvar k;
   generate
      for (k = 0; k < sector_protect_pkg::NUM_KINDS; k++) begin : g_kind
         localparam int CMD_BIT = (k == sector_protect_pkg::KIND_PERSIST) ?
                                  sector_protect_pkg::CMD_RD_PERSIST_BIT :
                                  sector_protect_pkg::CMD_RD_VOLATILE_BIT;
         localparam sector_protect_pkg::reg_sel_t STATUS_SEL =
            (k == sector_protect_pkg::KIND_PERSIST) ?
            sector_protect_pkg::SEL_PERSIST : sector_protect_pkg::SEL_VOLATILE;

         assign rd_cmd[k] = do_write && lane0 && wr_sel == sector_protect_pkg::SEL_COMMAND
                            && w_data_q[CMD_BIT];
         assign wr_status[k] = do_write && lane0 && wr_sel == STATUS_SEL;

         // Writing the status byte programs the selected sector's lock bit
         lock_bit_store u_store (
            .clk_sys(clk_sys),
            .rst(rst),
            .ce(ce),
            .wr_en(wr_status[k]),
            .wr_sector(sector_sel_q),
            .wr_bit(w_data_q[sector_protect_pkg::STATUS_LSB]),
            .rd_sector(sector_sel_q),
            .rd_bit(rd_bit[k])
         );

         // A read command samples the selected sector's bit
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               status_q[k] <= sector_protect_pkg::STATUS_ALL_ONES;
            end else if (ce) begin
               if (wr_status[k]) begin
                  status_q[k] <= fill_byte(w_data_q[sector_protect_pkg::STATUS_LSB]);
               end else if (rd_cmd[k]) begin
                  status_q[k] <= fill_byte(rd_bit[k]);
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   sector_protect_pkg::reg_sel_t rd_sel;
   logic [sector_protect_pkg::DATA_W-1:0] rd_word;

   assign rd_sel = decode_addr(s_axi_araddr);

   always_comb begin
      rd_word = '0;
      case (rd_sel)
         sector_protect_pkg::SEL_SECTOR: rd_word[sector_protect_pkg::SECTOR_W-1:0] = sector_sel_q;
         sector_protect_pkg::SEL_PERSIST: begin
            rd_word[sector_protect_pkg::STATUS_W-1:0] = status_q[sector_protect_pkg::KIND_PERSIST];
         end
         sector_protect_pkg::SEL_VOLATILE: begin
            rd_word[sector_protect_pkg::STATUS_W-1:0] = status_q[sector_protect_pkg::KIND_VOLATILE];
         end
         default: rd_word = '0;
      endcase
   end

   // The command register reads as zero; it only triggers sampling
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= sector_protect_pkg::RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (rd_sel == sector_protect_pkg::SEL_NONE) ?
                           sector_protect_pkg::RESP_SLVERR : sector_protect_pkg::RESP_OKAY;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   logic [sector_protect_pkg::NUM_KINDS-1:0] touched_q;
   logic [sector_protect_pkg::STATUS_W-1:0] persist_b;
   logic [sector_protect_pkg::STATUS_W-1:0] volatile_b;

   assign persist_b = status_q[sector_protect_pkg::KIND_PERSIST];
   assign volatile_b = status_q[sector_protect_pkg::KIND_VOLATILE];

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         touched_q <= '0;
      end else if (ce) begin
         touched_q <= touched_q | rd_cmd | wr_status;
      end
   end

   property p_persist_holds;
      @(posedge clk_sys) disable iff (rst)
      !(ce && (rd_cmd[0] || wr_status[0])) |=> $stable(persist_b);
   endproperty
   a_persist_holds: assert property (p_persist_holds) else $error("persist status moved");

   property p_persist_value;
      @(posedge clk_sys) disable iff (rst)
      (ce && rd_cmd[0] && !wr_status[0]) |=> (persist_b == 8'hff) == $past(rd_bit[0]);
   endproperty
   a_persist_value: assert property (p_persist_value) else $error("persist value wrong");

   property p_persist_default;
      @(posedge clk_sys) disable iff (rst)
      !touched_q[0] |-> persist_b == 8'hff;
   endproperty
   a_persist_default: assert property (p_persist_default) else $error("persist default");

   // The stored lock bit and the byte both follow a status write at once
   property p_persist_write_back;
      @(posedge clk_sys) disable iff (rst)
      (ce && wr_status[sector_protect_pkg::KIND_PERSIST])
      |=> (rd_bit[sector_protect_pkg::KIND_PERSIST] ==
           $past(w_data_q[sector_protect_pkg::STATUS_LSB]))
          && (persist_b == fill_byte($past(w_data_q[sector_protect_pkg::STATUS_LSB])));
   endproperty
   a_persist_write_back: assert property (p_persist_write_back) else $error("persist rw");

   property p_volatile_holds;
      @(posedge clk_sys) disable iff (rst)
      !(ce && (rd_cmd[1] || wr_status[1])) |=> $stable(volatile_b);
   endproperty
   a_volatile_holds: assert property (p_volatile_holds) else $error("volatile moved");

   property p_volatile_value;
      @(posedge clk_sys) disable iff (rst)
      (ce && rd_cmd[1] && !wr_status[1]) |=> (volatile_b == 8'h00) == !$past(rd_bit[1]);
   endproperty
   a_volatile_value: assert property (p_volatile_value) else $error("volatile value");

   property p_volatile_default;
      @(posedge clk_sys) disable iff (rst)
      !touched_q[1] |-> volatile_b == 8'hff;
   endproperty
   a_volatile_default: assert property (p_volatile_default) else $error("volatile default");

   property p_uniform_bytes;
      @(posedge clk_sys) disable iff (rst)
      (persist_b == 8'hff || persist_b == 8'h00) && (volatile_b == 8'hff || volatile_b == 8'h00);
   endproperty
   a_uniform_bytes: assert property (p_uniform_bytes) else $error("mixed status bits");

   property p_cover_locked;
      @(posedge clk_sys) disable iff (rst)
      (ce && rd_cmd[0]) ##1 persist_b == 8'h00;
   endproperty
   c_cover_locked: cover property (p_cover_locked);

   property p_cover_volatile_write;
      @(posedge clk_sys) disable iff (rst)
      (ce && wr_status[1]) ##1 volatile_b == 8'h00;
   endproperty
   c_cover_volatile_write: cover property (p_cover_volatile_write);

   property p_cover_slverr;
      @(posedge clk_sys) disable iff (rst)
      s_axi_bvalid && s_axi_bresp == sector_protect_pkg::RESP_SLVERR;
   endproperty
   c_cover_slverr: cover property (p_cover_slverr);

endmodule
`default_nettype wire

// >>> testbench/axi_host_model.sv
// Host controller model: AXI4-Lite master that issues one write and one read at a time
`timescale 1ns/100ps
`default_nettype none
module axi_host_model (
   // Clock and enable
   input wire logic clk_sys,
   input wire logic ce,
   // Write address and data
   output var logic [7:0] awaddr,
   output var logic awvalid,
   input wire logic awready,
   output var logic [31:0] wdata,
   output var logic [3:0] wstrb,
   output var logic wvalid,
   input wire logic wready,
   // Write response
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output var logic bready,
   // Read address and data
   output var logic [7:0] araddr,
   output var logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output var logic rready
);
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid} = '0;
      {araddr, arvalid} = '0;
      // Response readies stay high, so back-to-back calls never drive them twice at once
      bready = 1'b1;
      rready = 1'b1;
   end

   // Released address and data lines carry the inverse, so a slave latching late sees wrong data
   task automatic write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
      bit aw_done;
      bit w_done;
      aw_done = 0;
      w_done = 0;
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge clk_sys);
         if (!aw_done && awready && ce) begin
            aw_done = 1;
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         if (!w_done && wready && ce) begin
            w_done = 1;
            wvalid <= 1'b0;
            wdata <= ~d;
         end
      end
      do @(posedge clk_sys); while (!(bvalid && ce));
      r = bresp;
   endtask

   task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      bit ar_done;
      ar_done = 0;
      araddr <= a;
      arvalid <= 1'b1;
      forever begin
         @(posedge clk_sys);
         if (!ar_done && arready && ce) begin
            ar_done = 1;
            arvalid <= 1'b0;
            araddr <= ~a;
         end else if (ar_done && rvalid && ce) begin
            break;
         end
      end
      d = rdata;
      r = rresp;
   endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the sector protection status block
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic clk_sys, rst, ce;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rdat;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   int bad_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int lock_m[2][256];
   int st_m[2];
   int s, k, b, cmd;
   bit ce_jitter = 0;

   sector_protect_status_read sector_protect_status_read_i (.clk_sys(clk_sys), .rst(rst),
      .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   axi_host_model axi_host_model_i (.clk_sys(clk_sys), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

   initial begin
      clk_sys = 0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [33:0] got, input logic [33:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Model: lock bits and latched status bytes, all ones after reset
   task automatic model_reset();
      foreach (lock_m[i, j]) lock_m[i][j] = 1;
      st_m = '{255, 255};
   endtask

   function automatic logic [7:0] stat_off(input int kind);
      return kind ? sector_protect_pkg::OFF_VOLATILE_STATUS : sector_protect_pkg::OFF_PERSIST_STATUS;
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      axi_host_model_i.write(a, d, 4'hf, resp);
      check(34'(resp), 34'(sector_protect_pkg::RESP_OKAY));
   endtask

   task automatic rd_cmp(input logic [7:0] a, input int exp);
      axi_host_model_i.read(a, rdat, resp);
      check({resp, rdat}, {sector_protect_pkg::RESP_OKAY, 32'(exp)});
   endtask

   task automatic reset_dut();
      rst <= 1'b1;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      model_reset();
      @(posedge clk_sys);
   endtask

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         conclude();
      end
   end

   // Random stalls freeze design and host alike; both sample ce at the edge
   always @(posedge clk_sys) begin
      ce <= ce_jitter ? ($urandom % 4 != 0) : 1'b1;
   end

   initial begin
      rst = 1'b1;
      ce = 1'b1;
      void'($urandom(32'h05f7038d));
      reset_dut();
      // ----------------------------------------------------------------
      // Reset values
      // ----------------------------------------------------------------
      rd_cmp(stat_off(0), 255);
      rd_cmp(stat_off(1), 255);
      $display("test reset_values done");
      // ----------------------------------------------------------------
      // Program random lock bits, then query through commands
      // ----------------------------------------------------------------
      ce_jitter = 1;
      for (int n = 0; n < 40; n++) begin
         s = $urandom % 256;
         k = $urandom % 2;
         b = $urandom % 2;
         wr(sector_protect_pkg::OFF_SECTOR_SEL, 32'(s));
         rd_cmp(sector_protect_pkg::OFF_SECTOR_SEL, s);
         wr(stat_off(k), ($urandom & 32'hffff_fffe) | 32'(b));
         lock_m[k][s] = b;
         st_m[k] = b ? 255 : 0;
         rd_cmp(stat_off(k), st_m[k]);
         if ($urandom % 2)
            s = $urandom % 256;
         cmd = 1 + $urandom % 3;
         wr(sector_protect_pkg::OFF_SECTOR_SEL, 32'(s));
         wr(sector_protect_pkg::OFF_COMMAND, 32'(cmd));
         rd_cmp(sector_protect_pkg::OFF_COMMAND, 0);
         for (int j = 0; j < 2; j++)
            if (cmd[j])
               st_m[j] = lock_m[j][s] ? 255 : 0;
         rd_cmp(stat_off(0), st_m[0]);
         rd_cmp(stat_off(1), st_m[1]);
      end
      $display("test lock_query done");
      // ----------------------------------------------------------------
      // Masked write and unmapped address
      // ----------------------------------------------------------------
      axi_host_model_i.write(stat_off(0), 32'(~st_m[0] & 1), 4'he, resp);
      check(34'(resp), 34'(sector_protect_pkg::RESP_OKAY));
      rd_cmp(stat_off(0), st_m[0]);
      axi_host_model_i.write(8'h10, 32'h0000_0000, 4'hf, resp);
      check(34'(resp), 34'(sector_protect_pkg::RESP_SLVERR));
      axi_host_model_i.read(8'h10, rdat, resp);
      check({resp, rdat}, {sector_protect_pkg::RESP_SLVERR, 32'h0000_0000});
      $display("test masked_unmapped done");
      // ----------------------------------------------------------------
      // Second reset restores defaults of both bytes and lock bits
      // ----------------------------------------------------------------
      wr(sector_protect_pkg::OFF_SECTOR_SEL, 32'h0000_0005);
      wr(stat_off(0), 32'h0000_0000);
      wr(stat_off(1), 32'h0000_0000);
      reset_dut();
      rd_cmp(stat_off(0), 255);
      rd_cmp(stat_off(1), 255);
      wr(sector_protect_pkg::OFF_SECTOR_SEL, 32'h0000_0005);
      wr(sector_protect_pkg::OFF_COMMAND, 32'h0000_0003);
      rd_cmp(stat_off(0), 255);
      rd_cmp(stat_off(1), 255);
      $display("test second_reset done");
      conclude();
   end
endmodule
`default_nettype wire
